// >>> logic/irc_map.svh
// register offsets, field positions and reset values of the rate and control block
`ifndef IRC_MAP_SVH
`define IRC_MAP_SVH
// byte addresses on the register bus
`define IRC_ADR_DIV 4'h0
`define IRC_ADR_CTRL 4'h4
`define IRC_ADR_STAT 4'h8
// divider_register fields
`define IRC_DIV_SCALE_FACTOR_FIELD_HI 7
`define IRC_DIV_SCALE_FACTOR_FIELD_LO 6
`define IRC_DIV_CODE_HI 5
// bus_control fields
`define IRC_CTRL_EN 7
`define IRC_CTRL_IE 6
`define IRC_CTRL_MST 5
`define IRC_CTRL_TX 4
`define IRC_CTRL_ACK_DRIVE_SELECT 3
`define IRC_CTRL_REPEATED_START_REQUEST 2
// bits that are stored; repeated start and the low reserved bits are not
`define IRC_CTRL_WMASK 8'hF8
// status fields
`define IRC_STAT_BUSY 0
`define IRC_STAT_ARB 1
`define IRC_STAT_MACT 2
// reset values
`define IRC_DIV_RST 8'h00
`define IRC_CTRL_RST 8'h00
`endif

// >>> logic/irc_pkg.sv
// shared types of the rate and control block
package irc_pkg;
  // bus condition sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START,
    ST_START_SCL,
    ST_CLOCK,
    ST_STOP_LOW,
    ST_STOP_SCL,
    ST_STOP_SDA,
    ST_RS_LOW,
    ST_RS_SCL
  } irc_state_e;
endpackage : irc_pkg

// >>> logic/irc_rate_rom.sv
// fixed 64-entry lookup of scl divider and sda hold count, registered read data
`timescale 1ns/1ps
module irc_rate_rom (
  input wire logic clk_i,
  input wire logic [5:0] code_i,
  output logic [11:0] div_o,
  output logic [9:0] hold_o
);
  logic [21:0] ent_next; // {divider, hold} for the current code
  logic [21:0] ent_reg; // registered entry

  // table decode, one entry per rate code
  always_comb begin
    case (code_i)
      6'h00: ent_next = {12'h014, 10'h007};
      6'h01: ent_next = {12'h016, 10'h007};
      6'h02: ent_next = {12'h018, 10'h008};
      6'h03: ent_next = {12'h01A, 10'h008};
      6'h04: ent_next = {12'h01C, 10'h009};
      6'h05: ent_next = {12'h01E, 10'h009};
      6'h06: ent_next = {12'h022, 10'h00A};
      6'h07: ent_next = {12'h028, 10'h00A};
      6'h08: ent_next = {12'h01C, 10'h007};
      6'h09: ent_next = {12'h020, 10'h007};
      6'h0A: ent_next = {12'h024, 10'h009};
      6'h0B: ent_next = {12'h028, 10'h009};
      6'h0C: ent_next = {12'h02C, 10'h00B};
      6'h0D: ent_next = {12'h030, 10'h00B};
      6'h0E: ent_next = {12'h038, 10'h00D};
      6'h0F: ent_next = {12'h044, 10'h00D};
      6'h10: ent_next = {12'h030, 10'h009};
      6'h11: ent_next = {12'h038, 10'h009};
      6'h12: ent_next = {12'h040, 10'h00D};
      6'h13: ent_next = {12'h048, 10'h00D};
      6'h14: ent_next = {12'h050, 10'h011};
      6'h15: ent_next = {12'h058, 10'h011};
      6'h16: ent_next = {12'h068, 10'h015};
      6'h17: ent_next = {12'h080, 10'h015};
      6'h18: ent_next = {12'h050, 10'h009};
      6'h19: ent_next = {12'h060, 10'h009};
      6'h1A: ent_next = {12'h070, 10'h011};
      6'h1B: ent_next = {12'h080, 10'h011};
      6'h1C: ent_next = {12'h090, 10'h019};
      6'h1D: ent_next = {12'h0A0, 10'h019};
      6'h1E: ent_next = {12'h0C0, 10'h021};
      6'h1F: ent_next = {12'h0F0, 10'h021};
      6'h20: ent_next = {12'h0A0, 10'h011};
      6'h21: ent_next = {12'h0C0, 10'h011};
      6'h22: ent_next = {12'h0E0, 10'h021};
      6'h23: ent_next = {12'h100, 10'h021};
      6'h24: ent_next = {12'h120, 10'h031};
      6'h25: ent_next = {12'h140, 10'h031};
      6'h26: ent_next = {12'h180, 10'h041};
      6'h27: ent_next = {12'h1E0, 10'h041};
      6'h28: ent_next = {12'h140, 10'h021};
      6'h29: ent_next = {12'h180, 10'h021};
      6'h2A: ent_next = {12'h1C0, 10'h041};
      6'h2B: ent_next = {12'h200, 10'h041};
      6'h2C: ent_next = {12'h240, 10'h061};
      6'h2D: ent_next = {12'h280, 10'h061};
      6'h2E: ent_next = {12'h300, 10'h081};
      6'h2F: ent_next = {12'h3C0, 10'h081};
      6'h30: ent_next = {12'h280, 10'h041};
      6'h31: ent_next = {12'h300, 10'h041};
      6'h32: ent_next = {12'h380, 10'h081};
      6'h33: ent_next = {12'h400, 10'h081};
      6'h34: ent_next = {12'h480, 10'h0C1};
      6'h35: ent_next = {12'h500, 10'h0C1};
      6'h36: ent_next = {12'h600, 10'h101};
      6'h37: ent_next = {12'h780, 10'h101};
      6'h38: ent_next = {12'h500, 10'h081};
      6'h39: ent_next = {12'h600, 10'h081};
      6'h3A: ent_next = {12'h700, 10'h101};
      6'h3B: ent_next = {12'h800, 10'h101};
      6'h3C: ent_next = {12'h900, 10'h181};
      6'h3D: ent_next = {12'hA00, 10'h181};
      6'h3E: ent_next = {12'hC00, 10'h201};
      default: ent_next = {12'hF00, 10'h201};
    endcase
  end

  // read data register; a code change shows one cycle later
  always_ff @(posedge clk_i) begin
    ent_reg <= ent_next;
  end

  assign div_o = ent_reg[21:10];
  assign hold_o = ent_reg[9:0];

  // the slowest code gives the largest divider and hold
  rom_last_a: assert property (@(posedge clk_i) code_i == 6'h3F |=> div_o == 12'hF00 && hold_o == 10'h201) else $error("bad entry for last rate code");
  // the fastest code gives the smallest divider
  rom_first_a: assert property (@(posedge clk_i) code_i == 6'h00 |=> div_o == 12'h014 && hold_o == 10'h007) else $error("bad entry for first rate code");
endmodule : irc_rate_rom

// >>> logic/irc_half_timer.sv
// half-period tick divider for the serial clock
`timescale 1ns/1ps
module irc_half_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [13:0] half_i,
  output logic tick_o
);
  logic [13:0] cnt_reg; // cycles since last tick
  logic [13:0] cnt_next;
  logic tick_reg; // one-cycle enable pulse
  logic tick_next;

  // count half_i cycles, then pulse; idle holds the count at zero
  always_comb begin
    cnt_next = cnt_reg + 14'h0001;
    tick_next = 1'b0;
    if (!run_i) begin
      cnt_next = 14'h0000;
    end else if (cnt_reg >= half_i - 14'h0001) begin
      cnt_next = 14'h0000;
      tick_next = 1'b1;
    end
  end

  // register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 14'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;
endmodule : irc_half_timer

// >>> logic/irc_top.sv
// rate selection, control register and bus condition sequencer on a wishbone slave
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "irc_map.svh"

// What this block does
// - rate code selects divider and hold
// - bit rate is clock over factor times divider
// - factor field: 00 one, 01 two, 10 four
// - sda changes hold cycles after scl falls
// - enable bit switches the controller on
// - interrupt enable gates the request
// - master select rising makes start condition
// - master select falling makes stop condition
// - direction bit: one transmit, zero receive
// - ack drive bit sets sda in ack
// - repeated start request works only as master
// - repeated start request reads back zero
// - misplaced repeated start counts as lost arbitration
module irc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic ack_slot_i,
  input wire logic tx_bit_i,
  output logic dir_tx_o,
  output logic master_o,
  output logic irq_o
);
  // register bus
  logic ack_reg; // answer, one cycle after the request
  logic ack_next;
  logic [7:0] rdat_reg; // read data, loaded with the answer
  logic [7:0] rdat_next;
  logic req; // request present: cycle and strobe both high
  logic wr_any; // write takes effect at the edge the master sees ack
  logic wr_div;
  logic wr_ctrl;
  logic wr_stat;
  // software state
  logic [7:0] div_reg; // divider_register: factor and rate code
  logic [7:0] div_next;
  logic [7:0] ctrl_reg; // bus_control
  logic [7:0] ctrl_next;
  logic arb_reg; // lost arbitration flag, write one to clear
  logic arb_next;
  logic irq_reg;
  logic irq_next;
  // pin synchronisers and bus watch
  logic scl_meta_reg;
  logic scl_sync_reg;
  logic scl_prev_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic sda_prev_reg;
  logic busy_reg; // start seen, stop not yet
  logic busy_next;
  // sequencer
  irc_pkg::irc_state_e state_reg;
  irc_pkg::irc_state_e state_next;
  logic scl_oe_reg; // pull scl low
  logic scl_oe_next;
  logic sda_oe_reg; // pull sda low
  logic sda_oe_next;
  logic [9:0] hold_cnt_reg; // cycles left before sda may change
  logic [9:0] hold_cnt_next;
  logic start_req_reg;
  logic start_req_next;
  logic stop_req_reg;
  logic stop_req_next;
  logic rs_req_reg;
  logic rs_req_next;
  // rate
  logic [11:0] rom_div;
  logic [9:0] rom_hold;
  logic [13:0] full;
  logic [13:0] half;
  logic tick;
  // events
  logic en;
  logic mst_rise;
  logic mst_fall;
  logic master_now;
  logic rs_ok;
  logic rs_bad;
  logic arb_hit;
  logic lost;
  logic scl_fall;
  logic want_pull;

  irc_rate_rom u_rom (
    .clk_i(clk_i),
    .code_i(div_reg[`IRC_DIV_CODE_HI:0]),
    .div_o(rom_div),
    .hold_o(rom_hold)
  );

  irc_half_timer u_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(state_reg != irc_pkg::ST_IDLE),
    .half_i(half),
    .tick_o(tick)
  );

  // bit period is factor times divider; the timer counts half of it
  always_comb begin
    case (div_reg[`IRC_DIV_SCALE_FACTOR_FIELD_HI:`IRC_DIV_SCALE_FACTOR_FIELD_LO])
      2'b01: full = {2'b00, rom_div} << 1;
      2'b10: full = {2'b00, rom_div} << 2;
      default: full = {2'b00, rom_div}; // reserved code runs as factor one
    endcase
    half = full >> 1;
  end

  assign req = wb_cyc_i && wb_stb_i;
  assign wr_any = req && wb_we_i && ack_reg && wb_sel_i[0];
  assign wr_div = wr_any && wb_adr_i == `IRC_ADR_DIV;
  assign wr_ctrl = wr_any && wb_adr_i == `IRC_ADR_CTRL;
  assign wr_stat = wr_any && wb_adr_i == `IRC_ADR_STAT;
  assign en = ctrl_reg[`IRC_CTRL_EN];
  assign master_now = ctrl_reg[`IRC_CTRL_MST] && state_reg == irc_pkg::ST_CLOCK;
  // transitions are judged on the written value against the stored one
  assign mst_rise = wr_ctrl && wb_dat_i[`IRC_CTRL_MST] && !ctrl_reg[`IRC_CTRL_MST]
                    && wb_dat_i[`IRC_CTRL_EN];
  assign mst_fall = wr_ctrl && !wb_dat_i[`IRC_CTRL_MST] && ctrl_reg[`IRC_CTRL_MST];
  assign rs_ok = wr_ctrl && wb_dat_i[`IRC_CTRL_REPEATED_START_REQUEST] && master_now;
  assign rs_bad = wr_ctrl && wb_dat_i[`IRC_CTRL_REPEATED_START_REQUEST] && !master_now && en;
  // another master pulls sda while we release it with scl high
  assign arb_hit = state_reg == irc_pkg::ST_CLOCK && !scl_oe_reg && !sda_oe_reg
                   && !sda_sync_reg && scl_sync_reg && !ack_slot_i;
  assign lost = rs_bad || arb_hit;
  assign scl_fall = scl_prev_reg && !scl_sync_reg;
  // level wanted on sda for the current bit: ack slot of a receiver or data of a sender
  always_comb begin
    if (ack_slot_i && !ctrl_reg[`IRC_CTRL_TX]) begin
      want_pull = !ctrl_reg[`IRC_CTRL_ACK_DRIVE_SELECT];
    end else if (ctrl_reg[`IRC_CTRL_TX] && !ack_slot_i) begin
      want_pull = !tx_bit_i;
    end else begin
      want_pull = 1'b0;
    end
  end

  // bus slave: ack one cycle after the request, dropped the cycle after
  always_comb begin
    ack_next = req && !ack_reg;
    rdat_next = rdat_reg;
    if (req && !ack_reg) begin
      case (wb_adr_i)
        `IRC_ADR_DIV: rdat_next = div_reg;
        `IRC_ADR_CTRL: rdat_next = ctrl_reg;
        `IRC_ADR_STAT: rdat_next = {5'h00, master_now, arb_reg, busy_reg};
        default: rdat_next = 8'h00; // unmapped reads zero, still answered
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 8'h00;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // software registers; a hardware set of the flag beats a clear in the same cycle
  always_comb begin
    div_next = div_reg;
    ctrl_next = ctrl_reg;
    arb_next = arb_reg;
    if (wr_div) begin
      div_next = wb_dat_i[7:0];
    end
    if (wr_ctrl) begin
      ctrl_next = wb_dat_i[7:0] & `IRC_CTRL_WMASK;
    end
    if (wr_stat && wb_dat_i[`IRC_STAT_ARB]) begin
      arb_next = 1'b0;
    end
    if (lost) begin
      arb_next = 1'b1;
      ctrl_next[`IRC_CTRL_MST] = 1'b0;
    end
    irq_next = ctrl_next[`IRC_CTRL_EN] && ctrl_next[`IRC_CTRL_IE] && arb_next;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= `IRC_DIV_RST;
      ctrl_reg <= `IRC_CTRL_RST;
      arb_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      ctrl_reg <= ctrl_next;
      arb_reg <= arb_next;
      irq_reg <= irq_next;
    end
  end

  // bus watch: start sets busy, stop clears it; only meaningful while enabled
  always_comb begin
    busy_next = busy_reg;
    if (!en) begin
      busy_next = 1'b0;
    end else if (scl_sync_reg && sda_prev_reg && !sda_sync_reg) begin
      busy_next = 1'b1;
    end else if (scl_sync_reg && !sda_prev_reg && sda_sync_reg) begin
      busy_next = 1'b0;
    end
  end

  // two-stage synchronisers; the second stage and a delayed copy of it feed logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else begin
      scl_meta_reg <= scl_i;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_i;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      busy_reg <= busy_next;
    end
  end

  // sequencer: start, clocking, repeated start and stop, paced by half-period ticks
  always_comb begin
    state_next = state_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    hold_cnt_next = hold_cnt_reg;
    start_req_next = start_req_reg || mst_rise;
    stop_req_next = stop_req_reg || mst_fall;
    rs_req_next = rs_req_reg || rs_ok;
    // data changes wait out the hold count after scl falls
    if ((state_reg == irc_pkg::ST_IDLE || state_reg == irc_pkg::ST_CLOCK)
        && hold_cnt_reg != 10'h000) begin
      hold_cnt_next = hold_cnt_reg - 10'h001;
      if (hold_cnt_reg == 10'h001) begin
        sda_oe_next = want_pull;
      end
    end
    case (state_reg)
      irc_pkg::ST_IDLE: begin
        scl_oe_next = 1'b0;
        if (scl_fall && busy_reg) begin
          hold_cnt_next = rom_hold; // slave side uses the same hold
        end
        if (start_req_reg) begin
          start_req_next = mst_rise;
          stop_req_next = 1'b0;
          hold_cnt_next = 10'h000;
          state_next = irc_pkg::ST_START;
        end
      end
      irc_pkg::ST_START: begin
        if (tick) begin
          sda_oe_next = 1'b1; // sda falls while scl is high
          state_next = irc_pkg::ST_START_SCL;
        end
      end
      irc_pkg::ST_START_SCL: begin
        if (tick) begin
          scl_oe_next = 1'b1;
          hold_cnt_next = rom_hold;
          state_next = irc_pkg::ST_CLOCK;
        end
      end
      irc_pkg::ST_CLOCK: begin
        if (tick && !scl_oe_reg) begin
          scl_oe_next = 1'b1;
          hold_cnt_next = rom_hold;
          if (stop_req_reg) begin
            state_next = irc_pkg::ST_STOP_LOW;
          end else if (rs_req_reg) begin
            state_next = irc_pkg::ST_RS_LOW;
          end
        end else if (tick) begin
          scl_oe_next = 1'b0;
        end
      end
      irc_pkg::ST_STOP_LOW: begin
        if (tick) begin
          sda_oe_next = 1'b1;
          state_next = irc_pkg::ST_STOP_SCL;
        end
      end
      irc_pkg::ST_STOP_SCL: begin
        if (tick) begin
          scl_oe_next = 1'b0;
          state_next = irc_pkg::ST_STOP_SDA;
        end
      end
      irc_pkg::ST_STOP_SDA: begin
        if (tick) begin
          sda_oe_next = 1'b0; // sda rises while scl is high
          stop_req_next = 1'b0;
          hold_cnt_next = 10'h000; // a stale hold would pull sda on the idle bus
          state_next = irc_pkg::ST_IDLE;
        end
      end
      irc_pkg::ST_RS_LOW: begin
        if (tick) begin
          sda_oe_next = 1'b0;
          state_next = irc_pkg::ST_RS_SCL;
        end
      end
      irc_pkg::ST_RS_SCL: begin
        if (tick) begin
          scl_oe_next = 1'b0;
          rs_req_next = 1'b0;
          state_next = irc_pkg::ST_START;
        end
      end
      default: begin
        state_next = irc_pkg::ST_IDLE;
      end
    endcase
    // lost arbitration drops the bus at once, without a stop
    if (lost) begin
      state_next = irc_pkg::ST_IDLE;
      scl_oe_next = 1'b0;
      sda_oe_next = 1'b0;
      start_req_next = 1'b0;
      stop_req_next = 1'b0;
      rs_req_next = 1'b0;
    end
    // disabled: lines released, requests and bus activity ignored
    if (!en) begin
      state_next = irc_pkg::ST_IDLE;
      scl_oe_next = 1'b0;
      sda_oe_next = 1'b0;
      hold_cnt_next = 10'h000;
      start_req_next = mst_rise;
      stop_req_next = 1'b0;
      rs_req_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= irc_pkg::ST_IDLE;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      hold_cnt_reg <= 10'h000;
      start_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
      rs_req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      hold_cnt_reg <= hold_cnt_next;
      start_req_reg <= start_req_next;
      stop_req_reg <= stop_req_next;
      rs_req_reg <= rs_req_next;
    end
  end

  // open-drain pins: the driven level is always low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_oe_reg;
  assign sda_oe_o = sda_oe_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = {24'h00_0000, rdat_reg};
  assign dir_tx_o = ctrl_reg[`IRC_CTRL_TX];
  assign master_o = ctrl_reg[`IRC_CTRL_MST];
  assign irq_o = irq_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence mst_rise_s;
    mst_rise && state_reg == irc_pkg::ST_IDLE;
  endsequence
  sequence start_go_s;
    start_req_reg ##1 state_reg == irc_pkg::ST_START;
  endsequence

  scale_four_a: assert property (div_reg[7:6] == 2'b10 |-> half == {1'b0, rom_div, 1'b0}) else $error("factor four not applied");
  hold_wait_a: assert property (state_reg == irc_pkg::ST_CLOCK && hold_cnt_reg > 10'h001 && en && !lost && !tick |=> $stable(sda_oe_reg)) else $error("sda moved inside hold");
  off_release_a: assert property (!en |=> !scl_oe_o && !sda_oe_o) else $error("lines held while disabled");
  irq_gate_a: assert property (!ctrl_reg[`IRC_CTRL_IE] |-> !irq_o) else $error("interrupt raised while gated");
  start_make_a: assert property (mst_rise_s |=> start_go_s) else $error("no start after master select");
  stop_make_a: assert property (mst_fall && en && !lost |=> stop_req_reg) else $error("no stop after master release");
  ack_drive_a: assert property (hold_cnt_reg == 10'h001 && ack_slot_i && !ctrl_reg[`IRC_CTRL_TX] && en && !lost && state_reg == irc_pkg::ST_CLOCK && !tick |=> sda_oe_reg == !$past(ctrl_reg[`IRC_CTRL_ACK_DRIVE_SELECT])) else $error("ack level wrong");
  rs_read_a: assert property (req && !wb_we_i && !ack_reg && wb_adr_i == `IRC_ADR_CTRL |=> wb_ack_o && !wb_dat_o[`IRC_CTRL_REPEATED_START_REQUEST]) else $error("repeat start bit read as one");
  rs_bad_a: assert property (rs_bad |=> arb_reg && !ctrl_reg[`IRC_CTRL_MST] && state_reg == irc_pkg::ST_IDLE) else $error("misplaced repeat start not lost");
  rs_take_a: assert property (rs_ok && en |=> rs_req_reg) else $error("repeat start not taken");
endmodule : irc_top

// >>> tb/irc_bus_model.sv
// open-drain serial bus with pull-ups and a far-side device
`timescale 1ns/1ps
module irc_bus_model (
  input wire logic scl_oe_i,
  input wire logic sda_oe_i,
  input wire logic pull_sda_i,
  output logic scl_o,
  output logic sda_o
);
  // wired-and: a released line floats up to the pull-up level
  assign scl_o = ~scl_oe_i;
  // far side may only ever pull data low, never drive it high
  assign sda_o = ~(sda_oe_i | pull_sda_i);
endmodule : irc_bus_model

// >>> tb/irc_top_tb_top.sv
// self-checking bench of the rate and control block
`timescale 1ns/1ps
`include "irc_map.svh"
module irc_top_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0; // cycle and strobe rise together
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic ack_slot = 1'b0;
  logic tx_bit = 1'b1;
  logic [31:0] rdat;
  logic ack, scl_oe, sda_oe, scl, sda, dir_tx, master, irq;
  logic scl_drv, sda_drv; // driven pin levels, always low for open drain
  logic far_pull = 1'b0; // another device pulling the data line
  logic [7:0] q; // last read byte
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int h, a, b;
  // rate cases: {factor, code}, full period and hold in clocks
  logic [7:0] dv [3] = '{8'h00, 8'h4B, 8'hBF};
  int per [3] = '{20, 80, 15360};
  int hld [3] = '{7, 9, 513};
  // drive cases: {control, ack slot, data bit} and expected pull
  logic [9:0] dt [5] = '{10'h282, 10'h2A2, 10'h280, 10'h2C0, 10'h2C1};
  logic ex [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  irc_top i_irc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .scl_i(scl), .scl_o(scl_drv), .scl_oe_o(scl_oe), .sda_i(sda),
    .sda_o(sda_drv),
    .sda_oe_o(sda_oe), .ack_slot_i(ack_slot), .tx_bit_i(tx_bit), .dir_tx_o(dir_tx),
    .master_o(master), .irq_o(irq));
  irc_bus_model i_irc_bus_model (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
    .pull_sda_i(far_pull), .scl_o(scl), .sda_o(sda));
  // free-running 250 MHz clock
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // one place that prints counts and the verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // hang guard, sized above the slowest rate case
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // classic single cycle; waits for ack, read data taken at that edge
  task automatic wb(input logic w, input logic [3:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= {24'h00_0000, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n++ < 50) @(posedge clk_i);
    if (n > 50) miscompares++;
    q = rdat[7:0];
    cyc <= 1'b0;
  endtask : wb
  // counts clocks until a pin enable reaches a level
  task automatic wait_pin(input bit s, input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (((s ? sda_oe : scl_oe) !== v) && n < 30000);
    if (n >= 30000) miscompares++;
  endtask : wait_pin
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `IRC_ADR_DIV, 8'h00);
    check("div reset", q, `IRC_DIV_RST);
    wb(0, `IRC_ADR_CTRL, 8'h00);
    check("ctrl reset", q, `IRC_CTRL_RST);
    wb(0, 4'hC, 8'h00);
    check("unmapped", q, 8'h00);
    check("upper", rdat[31:8], 24'h00_0000);
    check("pin level", {scl_drv, sda_drv}, 2'b00);
    $display("test reset done");
    // a transmit frame per rate case, measured at the pins
    for (int i = 0; i < 3; i++) begin
      wb(1, `IRC_ADR_DIV, dv[i]);
      wb(1, `IRC_ADR_CTRL, 8'h90);
      wb(1, `IRC_ADR_CTRL, 8'hB0);
      wait_pin(0, 1, a);
      check("start master", master, 1'b1);
      wait_pin(1, 0, h);
      wait_pin(0, 0, a);
      wait_pin(0, 1, b);
      check("hold", h, hld[i]);
      check("period", h + a + b, per[i]);
      wb(1, `IRC_ADR_CTRL, 8'h90);
      wait_pin(1, 1, a);
      wait_pin(1, 0, a);
      check("stop scl", scl_oe, 1'b0);
      check("stop mode", master, 1'b0);
    end
    $display("test rates done");
    // data line drive per direction and acknowledge setting
    wb(1, `IRC_ADR_DIV, 8'h00);
    wb(1, `IRC_ADR_CTRL, 8'hB0);
    wait_pin(0, 1, a);
    for (int i = 0; i < 5; i++) begin
      wb(1, `IRC_ADR_CTRL, dt[i][9:2]);
      ack_slot <= dt[i][1];
      tx_bit <= dt[i][0];
      wait_pin(0, 0, a);
      wait_pin(0, 1, a);
      repeat (9) @(posedge clk_i);
      check("sda drive", sda_oe, ex[i]);
      check("direction", dir_tx, dt[i][6]);
    end
    // repeat start while clocking as master keeps the bus
    wb(1, `IRC_ADR_CTRL, 8'hB4);
    repeat (60) @(posedge clk_i);
    check("rs master", master, 1'b1);
    wb(0, `IRC_ADR_STAT, 8'h00);
    check("rs lost", q[1], 1'b0);
    wb(1, `IRC_ADR_CTRL, 8'h90);
    repeat (100) @(posedge clk_i);
    check("released", {scl_oe, sda_oe}, 2'b00);
    // another device pulls data while we send a one: we lose and let go
    wb(1, `IRC_ADR_CTRL, 8'hB0);
    wait_pin(0, 1, a);
    wait_pin(0, 0, a);
    far_pull <= 1'b1;
    repeat (8) @(posedge clk_i);
    check("far lost", master, 1'b0);
    check("far lines", {scl_oe, sda_oe}, 2'b00);
    far_pull <= 1'b0;
    wb(0, `IRC_ADR_STAT, 8'h00);
    check("far flag", q[1], 1'b1);
    wb(1, `IRC_ADR_STAT, 8'h02);
    $display("test drive done");
    // repeat start from idle is a lost arbitration
    wb(1, `IRC_ADR_CTRL, 8'hC4);
    wb(0, `IRC_ADR_STAT, 8'h00);
    check("bad rs lost", q[1], 1'b1);
    check("irq on", irq, 1'b1);
    wb(0, `IRC_ADR_CTRL, 8'h00);
    check("rs reads 0", q, 8'hC0);
    wb(1, `IRC_ADR_CTRL, 8'h80);
    wb(0, `IRC_ADR_CTRL, 8'h00);
    check("irq gated", irq, 1'b0);
    wb(1, `IRC_ADR_STAT, 8'h02);
    wb(0, `IRC_ADR_STAT, 8'h00);
    check("lost clear", q[1], 1'b0);
    // master request with the block switched off does nothing
    wb(1, `IRC_ADR_CTRL, 8'h20);
    repeat (50) @(posedge clk_i);
    check("off lines", {scl_oe, sda_oe}, 2'b00);
    // reset in mid-run returns the control register to its reset value
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `IRC_ADR_CTRL, 8'h00);
    check("ctrl rerst", q, `IRC_CTRL_RST);
    $display("test control done");
    wrap_up();
  end
endmodule : irc_top_tb_top
